// ==== dct_mtq_div.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dct_params.svh"

module dct_mtq_div
(
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  restart_i,
    input  wire logic [`DCT_DIV_W-1:0] div_i,
    output var  logic                  tick_o
);
    import dct_pkg::*;

    dct_div_s s_r;
    dct_div_s s_nxt;
    logic     last;

    ////////////////////////////////////////////////////////////////////////
    // one pulse every div_i clocks, zero treated as one
    always_comb
    begin
        s_nxt = s_r;
        last  = ({1'b0, s_r.cnt_r} + 9'h001) >= {1'b0, div_i};
        if (restart_i)
        begin
            s_nxt.cnt_r  = '0;
            s_nxt.tick_r = 1'b0;
        end
        else
        begin
            s_nxt.tick_r = last;
            s_nxt.cnt_r  = last ? '0 : s_r.cnt_r + 8'h01;
        end
    end

    // state register
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick_o = s_r.tick_r;

endmodule

`default_nettype wire

// ==== dct_params.svh ====
`ifndef DCT_PARAMS_SVH
`define DCT_PARAMS_SVH

// register word indices on the avalon slave
`define DCT_REG_CTRL     2'h0
`define DCT_REG_STATUS   2'h1
`define DCT_REG_MTQDIV   2'h2

// control word fields
`define DCT_CTRL_EN      0
`define DCT_CTRL_OFS_LSB 8
`define DCT_CTRL_OFS_MSB 15
`define DCT_CTRL_FLT_LSB 16
`define DCT_CTRL_FLT_MSB 22

// status word fields
`define DCT_STAT_VAL_LSB 0
`define DCT_STAT_VAL_MSB 6
`define DCT_STAT_BUSY    8

// divider word fields and reset
`define DCT_DIV_LSB      0
`define DCT_DIV_MSB      7
`define DCT_DIV_W        8
`define DCT_DIV_RST      8'h01

// position limits and history depth
`define DCT_POS_MAX      7'h7f
`define DCT_HIST_DEPTH   128

`endif

// ==== dct_pkg.sv ====
package dct_pkg;

    `include "dct_params.svh"

    // delay measurement state
    typedef enum logic [0:0]
    {
        DCT_IDLE = 1'b0,
        DCT_MEAS = 1'b1
    } dct_meas_e;

    // strobes and levels from the protocol core
    typedef struct packed {
        logic tx_bit;        // bit the core wants on the bus
        logic bit_start;     // first cycle of a new bit on tx_bit
        logic fdf_res_edge;  // own falling edge from fdf to res
        logic fd_frame;      // current frame is an fd frame
        logic data_start;    // data phase begins
        logic crc_delim_sp;  // sample point of crc delimiter
        logic sample_point;  // normal sample point
    } dct_core_s;

    // complete state of the main block
    typedef struct packed {
        logic                        wait_r;
        logic [31:0]                 rdata_r;
        logic                        en_r;
        logic [7:0]                  ofs_r;
        logic [6:0]                  flt_r;
        logic [`DCT_DIV_W-1:0]       div_r;
        dct_meas_e                   meas_r;
        logic [6:0]                  dly_r;
        logic [6:0]                  val_r;
        logic                        tx_r;
        logic [`DCT_HIST_DEPTH-1:0]  txh_r;
        logic [`DCT_HIST_DEPTH-1:0]  sth_r;
        logic                        chk_r;
        logic                        err_r;
        logic                        ssp_r;
    } dct_state_s;

    // state of the quantum divider
    typedef struct packed {
        logic [`DCT_DIV_W-1:0] cnt_r;
        logic                  tick_r;
    } dct_div_s;

endpackage

// ==== dct_top.sv ====
// Overview of operation
// - data phase checks rx at secondary sample point
// - position is loop delay plus offset; the code adds half the offset (ofs_r[7:1])
// - offset shifts point within received bit
// - position truncated to whole core clocks
// - value readable, cleared on init, updated per frame
// - position saturates at 127 core clocks
// - checking stops at crc delimiter sample point
// - measurement starts at own fdf-res falling edge
// - measurement stops when edge returns on rx
// - delay counter steps one minimum time quantum
// - filter window sets minimum secondary position
// - earlier dominant rx edges ignored with filter
// - stop needs position at filter and rx low
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "dct_params.svh"

module dct_top
(
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             init_i,
    input  wire dct_pkg::dct_core_s core_i,
    input  wire logic             bus_rx_in_i,
    output var  logic             bus_tx_out_o,
    output var  logic             bit_err_o,
    output var  logic             ssp_strobe_o,
    output var  logic             meas_busy_o,
    output var  logic [6:0]       delay_comp_value_o,
    input  wire logic [1:0]       avs_address_i,
    input  wire logic             avs_read_i,
    input  wire logic             avs_write_i,
    input  wire logic [31:0]      avs_writedata_i,
    input  wire logic [3:0]       avs_byteenable_i,
    output var  logic [31:0]      avs_readdata_o,
    output var  logic             avs_waitrequest_o
);
    import dct_pkg::*;

    localparam dct_state_s DCT_RST = '{wait_r: 1'b1, div_r: `DCT_DIV_RST,
                                       meas_r: DCT_IDLE, default: '0};

    dct_state_s  s_r;
    dct_state_s  s_nxt;
    logic        req;
    logic        tick;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] div_word;
    logic [31:0] rd_word;
    logic [31:0] be_mask;
    logic [31:0] wr_word;
    logic [7:0]  pos_sum;
    logic [6:0]  pos_now;
    logic [8:0]  dly_sum;
    logic [6:0]  dly_step;
    logic        start;
    logic        stop;
    logic        abort;
    logic        ssp_hit;
    logic        ssp_miss;
    logic        use_ssp;

    ////////////////////////////////////////////////////////////////////////
    // minimum time quantum, restarted with every measurement
    dct_mtq_div u_div
    (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .restart_i (start),
        .div_i     (s_r.div_r),
        .tick_o    (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // register images and byte lane merge
    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[`DCT_CTRL_EN] = s_r.en_r;
        ctrl_word[`DCT_CTRL_OFS_MSB:`DCT_CTRL_OFS_LSB] = s_r.ofs_r;
        ctrl_word[`DCT_CTRL_FLT_MSB:`DCT_CTRL_FLT_LSB] = s_r.flt_r;
        stat_word = '0;
        stat_word[`DCT_STAT_VAL_MSB:`DCT_STAT_VAL_LSB] = s_r.val_r;
        stat_word[`DCT_STAT_BUSY] = (s_r.meas_r == DCT_MEAS);
        div_word = '0;
        div_word[`DCT_DIV_MSB:`DCT_DIV_LSB] = s_r.div_r;
        be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        case (avs_address_i)
            `DCT_REG_CTRL:   rd_word = ctrl_word;
            `DCT_REG_STATUS: rd_word = stat_word;
            `DCT_REG_MTQDIV: rd_word = div_word;
            default:         rd_word = '0;
        endcase
        wr_word = (rd_word & ~be_mask) | (avs_writedata_i & be_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // position, delay step and measurement conditions
    always_comb
    begin
        pos_sum = {1'b0, s_r.dly_r} + {1'b0, s_r.ofs_r[7:1]};
        pos_now = pos_sum[7] ? `DCT_POS_MAX : pos_sum[6:0];
        dly_sum  = {2'b00, s_r.dly_r} + {1'b0, s_r.div_r};
        dly_step = (dly_sum[8:7] != 2'b00) ? `DCT_POS_MAX : dly_sum[6:0];
        start = core_i.fdf_res_edge && core_i.fd_frame && s_r.en_r && !init_i;
        stop  = (s_r.meas_r == DCT_MEAS) && !bus_rx_in_i && (pos_now >= s_r.flt_r);
        abort = init_i || core_i.crc_delim_sp || !s_r.en_r;
        use_ssp  = s_r.en_r && s_r.chk_r;
        ssp_hit  = s_r.sth_r[s_r.val_r];
        ssp_miss = bus_rx_in_i != s_r.txh_r[s_r.val_r];
    end

    assign req = avs_read_i || avs_write_i;

    ////////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tx_r   = core_i.tx_bit;
        s_nxt.txh_r  = {s_r.txh_r[`DCT_HIST_DEPTH-2:0], core_i.tx_bit};
        s_nxt.sth_r  = {s_r.sth_r[`DCT_HIST_DEPTH-2:0], core_i.bit_start};
        s_nxt.err_r  = 1'b0;
        s_nxt.ssp_r  = 1'b0;

        // avalon slave: one wait cycle, then acknowledge
        s_nxt.wait_r = !(req && s_r.wait_r);
        if (req && s_r.wait_r)
            s_nxt.rdata_r = avs_read_i ? rd_word : '0;
        if (avs_write_i && !s_r.wait_r)
        begin
            case (avs_address_i)
                `DCT_REG_CTRL:
                begin
                    s_nxt.en_r  = wr_word[`DCT_CTRL_EN];
                    s_nxt.ofs_r = wr_word[`DCT_CTRL_OFS_MSB:`DCT_CTRL_OFS_LSB];
                    s_nxt.flt_r = wr_word[`DCT_CTRL_FLT_MSB:`DCT_CTRL_FLT_LSB];
                end
                `DCT_REG_MTQDIV:
                    s_nxt.div_r = wr_word[`DCT_DIV_MSB:`DCT_DIV_LSB];
                default:
                    s_nxt.div_r = s_r.div_r;
            endcase
        end

        if (init_i)
            s_nxt.val_r = '0;

        // measurement sequence
        case (s_r.meas_r)
            DCT_IDLE:
                s_nxt.meas_r = DCT_IDLE;
            DCT_MEAS:
            begin
                if (stop)
                begin
                    s_nxt.val_r  = pos_now;
                    s_nxt.meas_r = DCT_IDLE;
                end
                else if (abort)
                    s_nxt.meas_r = DCT_IDLE;
                else if (tick)
                    s_nxt.dly_r = dly_step;
            end
            default:
                s_nxt.meas_r = DCT_IDLE;
        endcase
        if (start)
        begin
            s_nxt.meas_r = DCT_MEAS;
            s_nxt.dly_r  = '0;
        end

        if (core_i.crc_delim_sp || init_i)
            s_nxt.chk_r = 1'b0;
        if (core_i.data_start)
        begin
            s_nxt.chk_r = 1'b1;
            // forget bit starts before data phase
            s_nxt.sth_r = `DCT_HIST_DEPTH'(core_i.bit_start);
        end

        if (use_ssp)
        begin
            s_nxt.ssp_r = ssp_hit;
            s_nxt.err_r = ssp_hit && ssp_miss;
        end
        else if (core_i.sample_point)
            s_nxt.err_r = bus_rx_in_i != s_r.tx_r;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_r <= DCT_RST;
        else
            s_r <= s_nxt;
    end

    // outputs straight from state
    assign bus_tx_out_o       = s_r.tx_r;
    assign bit_err_o          = s_r.err_r;
    assign ssp_strobe_o       = s_r.ssp_r;
    assign meas_busy_o        = (s_r.meas_r == DCT_MEAS);
    assign delay_comp_value_o = s_r.val_r;
    assign avs_readdata_o     = s_r.rdata_r;
    assign avs_waitrequest_o  = s_r.wait_r;

    ////////////////////////////////////////////////////////////////////////
    // checks on the block's own behaviour
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence seq_meas_run;
        (s_r.meas_r == DCT_MEAS) && !abort && !start;
    endsequence

    sequence seq_req_wait;
        req && s_r.wait_r;
    endsequence

    ssp_check_a: assert property (use_ssp && ssp_hit |=> bit_err_o == $past(ssp_miss))
        else $error("secondary point compare wrong");

    val_store_a: assert property (stop && !start |=> delay_comp_value_o == $past(pos_now))
        else $error("stored value not delay plus offset");

    val_sat_a: assert property (stop && pos_sum[7] |=> delay_comp_value_o == 7'h7f)
        else $error("position not clamped");

    val_clear_a: assert property (init_i && !stop |=> delay_comp_value_o == 7'h00)
        else $error("value not cleared on init");

    meas_start_a: assert property (start |=> meas_busy_o && s_r.dly_r == 7'h00)
        else $error("measurement did not start");

    filter_hold_a: assert property (seq_meas_run and (!bus_rx_in_i && pos_now < s_r.flt_r)
        |=> meas_busy_o)
        else $error("early edge ended measurement");

    // stop on filter and rx low
    meas_stop_a: assert property (stop && !start |=> !meas_busy_o)
        else $error("measurement did not stop");

    // counter moves only on quantum tick
    dly_step_a: assert property (seq_meas_run and (!tick && !stop)
        |=> $stable(s_r.dly_r))
        else $error("delay moved between quanta");

    crc_stop_a: assert property (core_i.crc_delim_sp && !core_i.data_start
        |=> !s_r.chk_r ##1 !ssp_strobe_o)
        else $error("checking continued after crc delimiter");

    dis_idle_a: assert property (!s_r.en_r && !meas_busy_o |=> !meas_busy_o)
        else $error("measurement while disabled");

    // bus answer after one wait cycle
    bus_ack_a: assert property (seq_req_wait |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("avalon acknowledge timing wrong");

    // no stale secondary point after data start
    hist_clear_a: assert property (core_i.data_start && !core_i.bit_start
        |=> !ssp_hit)
        else $error("stale secondary point kept at data start");

    // divider write lands at the acknowledge edge
    div_write_a: assert property (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i == `DCT_REG_MTQDIV
        |=> s_r.div_r == $past(avs_writedata_i[`DCT_DIV_MSB:`DCT_DIV_LSB]))
        else $error("divider write lost");

endmodule

`default_nettype wire

// ==== dct_xcvr_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module dct_xcvr_model
(
    input  wire logic       mclk_i,
    input  wire logic       tx_i,
    input  wire logic [4:0] delay_i,
    input  wire logic       glitch_i,
    input  wire logic       corrupt_i,
    output var  logic       rx_o
);
    logic [31:0] line_r = '1;

    ////////////////////////////////////////////////////////////////////////////////
    // loop through transceiver and bus, recessive while idle
    always_ff @(posedge mclk_i)
    begin
        line_r <= {line_r[30:0], tx_i};
    end

    // dominant glitch pulls rx low, corrupt flips the echo
    always_comb
    begin
        rx_o = (line_r[delay_i] ^ corrupt_i) & ~glitch_i;
    end
endmodule

`default_nettype wire

// ==== tb_dct.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dct_params.svh"

module tb;
    import dct_pkg::*;
    logic        mclk_i  = 1'b0;
    logic        rst_n   = 1'b0;
    logic        init    = 1'b0;
    dct_core_s   core    = '0;
    logic [1:0]  addr    = 2'h0;
    logic        rd      = 1'b0;
    logic        wr      = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  be      = 4'hf;
    logic [4:0]  dly     = 5'h04;
    logic        glitch  = 1'b0;
    logic        corrupt = 1'b0;
    wire  logic  rx;
    wire  logic  tx_out;
    wire  logic  bit_err;
    wire  logic  secondary_sample_point;
    wire  logic  busy;
    wire  logic  wait_rq;
    wire  logic [6:0]  value;
    wire  logic [31:0] rdout;
    logic [31:0] rdata;
    logic [31:0] seed    = 32'h0000_f7b1;
    logic [6:0]  v0;
    logic [6:0]  v1;
    logic        hit;
    logic [1:0]  notes[$];
    int          n_fail  = 0;
    int          checked = 0;
    int          cycles  = 0;
    int          d0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #10 mclk_i = ~mclk_i;

    dct_top dct_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n), .init_i(init), .core_i(core),
        .bus_rx_in_i(rx), .bus_tx_out_o(tx_out), .bit_err_o(bit_err), .ssp_strobe_o(secondary_sample_point),
        .meas_busy_o(busy), .delay_comp_value_o(value), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdout), .avs_waitrequest_o(wait_rq));

    dct_xcvr_model dct_xcvr_model_i (.mclk_i(mclk_i), .tx_i(tx_out), .delay_i(dly),
        .glitch_i(glitch), .corrupt_i(corrupt), .rx_o(rx));

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
            n_fail++;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // avalon cycle: hold request until waitrequest seen low
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge mclk_i);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        be    <= b;
        do
            @(posedge mclk_i);
        while (wait_rq !== 1'b0);
        rdata = rdout;
        rd    <= 1'b0;
        wr    <= 1'b0;
    endtask

    task automatic ctrl(input logic en, input logic [7:0] ofs, input logic [6:0] flt);
        bus(1'b1, `DCT_REG_CTRL, {9'h000, flt, ofs, 7'h00, en}, 4'hf);
    endtask

    // fd frame: recessive fdf bit, own falling edge into res, wait for the end
    task automatic frame(input logic [4:0] d, input int glitch_at, output logic [6:0] v);
        dly <= d;
        core.tx_bit <= 1'b1;
        tick(40);
        core.tx_bit       <= 1'b0;
        core.bit_start    <= 1'b1;
        core.fdf_res_edge <= 1'b1;
        tick(1);
        core.bit_start    <= 1'b0;
        core.fdf_res_edge <= 1'b0;
        if (glitch_at > 0)
        begin
            tick(glitch_at);
            glitch <= 1'b1;
            tick(1);
            glitch <= 1'b0;
        end
        hit = 1'b0;
        for (int n = 0; n < 100 && !(hit && busy === 1'b0); n++)
        begin
            tick(1);
            hit |= (busy === 1'b1);
        end
        bus(1'b0, `DCT_REG_STATUS, 32'h0000_0000, 4'hf);
        v = rdata[6:0];
    endtask

    // 20-cycle bit, normal sample point at cycle 14
    task automatic send_bit(input logic b, input logic bad, input logic [1:0] note);
        core.tx_bit    <= b;
        core.bit_start <= 1'b1;
        corrupt        <= bad;
        if (note != 2'b00)
            notes.push_back(note);
        tick(1);
        core.bit_start <= 1'b0;
        tick(13);
        core.sample_point <= 1'b1;
        tick(1);
        core.sample_point <= 1'b0;
        tick(5);
    endtask

    // data phase: 5 clean then 3 corrupted bits, crc delimiter, one bit after
    task automatic data_phase(input logic en_on);
        logic [31:0] r;
        core.data_start <= 1'b1;
        tick(1);
        core.data_start <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            send_bit(r[0], i >= 5, {en_on, i >= 5});
        end
        core.crc_delim_sp <= 1'b1;
        tick(1);
        core.crc_delim_sp <= 1'b0;
        send_bit(1'b0, 1'b1, 2'b01);
        corrupt <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // result monitor and timeout
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            n_fail++;
            end_sim();
        end
        if (secondary_sample_point === 1'b1 || bit_err === 1'b1)
            chk(32'({secondary_sample_point, bit_err}), 32'(notes.size() ? notes.pop_front() : 2'b00));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        tick(8);
        chk(32'({wait_rq, tx_out, bit_err, secondary_sample_point, busy, value}), 32'h0000_0800);
        tick(8);
        rst_n <= 1'b1;
        bus(1'b0, `DCT_REG_CTRL, 32'h0000_0000, 4'hf);
        chk(rdata, 32'h0000_0000);
        bus(1'b0, `DCT_REG_MTQDIV, 32'h0000_0000, 4'hf);
        chk(rdata, 32'h0000_0001);
        bus(1'b1, 2'h3, 32'hffff_ffff, 4'hf);
        bus(1'b0, 2'h3, 32'h0000_0000, 4'hf);
        chk(rdata, 32'h0000_0000);
        bus(1'b1, `DCT_REG_CTRL, 32'hffff_ffff, 4'b0010);
        bus(1'b0, `DCT_REG_CTRL, 32'h0000_0000, 4'hf);
        chk(rdata & 32'h007f_ff01, 32'h0000_ff00);
        // delays kept small so delay plus offset stays below six bits
        core.fd_frame <= 1'b1;
        d0 = 3 + int'(rnd() % 5);
        ctrl(1'b1, 8'h00, 7'h00);
        frame(5'(d0), 0, v0);
        chk(32'(hit), 32'h1);
        chk(32'(value), 32'(v0));
        frame(5'(d0 + 3), 0, v1);
        chk(32'(v1), 32'(v0) + 32'd3);
        ctrl(1'b1, 8'h0b, 7'h00);
        frame(5'(d0), 0, v1);
        chk(32'(v1), 32'(v0) + 32'd5);
        ctrl(1'b1, 8'hff, 7'h00);
        frame(5'(d0), 0, v1);
        chk(32'(v1), 32'h7f);
        ctrl(1'b1, 8'h00, 7'h00);
        frame(5'(d0), 1, v1);
        chk(32'(v1 < v0), 32'h1);
        ctrl(1'b1, 8'h00, v0 + 7'h04);
        frame(5'(d0), 1, v1);
        chk(32'(v1), 32'(v0) + 32'd4);
        bus(1'b1, `DCT_REG_MTQDIV, 32'h0000_0002, 4'hf);
        ctrl(1'b1, 8'h00, 7'h00);
        frame(5'(d0), 0, v1);
        chk(32'(v1[0]), 32'h0);
        bus(1'b1, `DCT_REG_MTQDIV, 32'h0000_0001, 4'hf);
        ctrl(1'b1, 8'h00, v0 + 7'h04);
        frame(5'(d0), 0, v0);
        core.fd_frame <= 1'b0;
        frame(5'(d0 + 2), 0, v1);
        chk(32'({hit, v1}), 32'(v0));
        core.fd_frame <= 1'b1;
        ctrl(1'b0, 8'h10, 7'h00);
        frame(5'(d0 + 2), 0, v1);
        chk(32'({hit, v1}), 32'(v0));
        data_phase(1'b0);
        init <= 1'b1;
        tick(2);
        init <= 1'b0;
        bus(1'b0, `DCT_REG_STATUS, 32'h0000_0000, 4'hf);
        chk(rdata & 32'h0000_007f, 32'h0000_0000);
        ctrl(1'b1, 8'h10, 7'h00);
        frame(5'(d0), 0, v1);
        data_phase(1'b1);
        tick(30);
        chk(32'(notes.size()), 32'h0);
        end_sim();
    end
endmodule

`default_nettype wire
